// ---- ubm_cfg.svh ----
// Constants for the serial baud and mode control block
`ifndef UBM_CFG_SVH
`define UBM_CFG_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define UBM_OFS_MODE      16'hff70
`define UBM_OFS_BAUD      16'hff71
`define UBM_OFS_PORTDIR   16'hff21
`define UBM_OFS_PORTLATCH 16'hff01
`define UBM_OFS_TXSHIFT   16'hff72
`define UBM_OFS_RXBUF     16'hff74
`define UBM_OFS_ERRSTAT   16'hff73
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UBM_RST_MODE      8'h01
`define UBM_RST_BAUD      8'h1f
`define UBM_RST_PORTDIR   8'hff
`define UBM_RST_PORTLATCH 8'h00
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UBM_BIT_POWER     7
`define UBM_BIT_TXEN      6
`define UBM_BIT_RXEN      5
`define UBM_BIT_STOP2     1
`define UBM_BIT_RSVD      5
`define UBM_BIT_TXPIN     0
`define UBM_BIT_RXPIN     1
`define UBM_BAUD_WMASK    8'hdf
`define UBM_FRAME_BITS    4'h9
`define UBM_DIV_W         5
`endif

// ---- ubm_pkg.sv ----
// Types for the serial baud and mode control block
package ubm_pkg;
   typedef enum logic [1:0] {
      UBM_CLK_TIMER = 2'h0,
      UBM_CLK_DIV2  = 2'h1,
      UBM_CLK_DIV8  = 2'h2,
      UBM_CLK_DIV32 = 2'h3
   } ubm_clksel_e;
   typedef enum logic [1:0] {
      UBM_IDLE = 2'h0,
      UBM_DATA = 2'h1,
      UBM_STOP = 2'h3
   } ubm_fsm_e;
endpackage

// ---- ubm_divider.sv ----
// Five-bit bit-rate divider with half-rate output toggle
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module ubm_divider (
   input  wire logic                  clk_sys_in,
   input  wire logic                  srst_in,
   input  wire logic                  run_in,
   input  wire logic                  base_tick_in,
   input  wire logic [`UBM_DIV_W-1:0] divisor_in,
   output logic                       bit_tick_out
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`UBM_DIV_W-1:0] cnt;  // Base clocks counted
      logic                  half; // Toggles each k base clocks
      logic                  tick; // One cycle per bit time
   } ubm_div_s;
   ubm_div_s st_reg;
   ubm_div_s st_next;

   // Count k base ticks; two periods make one bit time
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!run_in) begin
         // Held clear while its direction is disabled
         st_next.cnt  = '0;
         st_next.half = 1'b0;
      end else if (base_tick_in) begin
         if (st_reg.cnt == divisor_in - 5'h01) begin
            st_next.cnt  = '0;
            st_next.half = ~st_reg.half;
            st_next.tick = st_reg.half;
         end else begin
            st_next.cnt = st_reg.cnt + 5'h01;
         end
      end
   end

   // Register the state
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign bit_tick_out = st_reg.tick;
endmodule
`default_nettype wire

// ---- ubm_top.sv ----
// Baud generation, mode control and pin routing of the serial port
// Function
// - Select bits pick timer or divided clock
// - Divisor k from field, 8 to 31
// - Five-bit counter divides base clock by k
// - Bit rate is counter output halved
// - Baud register resets to 1F hex
// - All three clear gives stop mode
// - Power clear stops clock, resets circuit
// - Transmit enable clear resets transmitter
// - Receive enable clear resets receiver
// - Power clear forces receive input high
// - Transmit write starts transmission when enabled
// - One byte after start bit, full duplex
// - Disabled direction pin stays port function
// - Direction 0 output buffer on, 1 off
// - Separate divider counters for tx and rx
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module ubm_top (
   input  wire logic        clk_sys_in,
   input  wire logic        srst_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   input  wire logic        timer_output_clock_in,
   input  wire logic        serial_in_pin_in,
   input  wire logic        serial_out_pin_in,
   output logic             serial_out_pin_out,
   output logic             serial_out_pin_oe_out,
   output logic             serial_in_pin_out,
   output logic             serial_in_pin_oe_out,
   output logic             rx_done_out
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  mode;      // Serial mode control
      logic [7:0]  baud;      // Baud divider control
      logic [7:0]  dir;       // Port 1 direction
      logic [7:0]  latch;     // Port 1 output latch
      logic [4:0]  pre;       // Main clock prescaler
      logic [2:0]  tmr_sync;  // Timer output sync and edge
      logic [1:0]  rx_sync;   // Receive pin synchroniser
      logic [8:0]  tx_sh;     // Transmit shift with start bit
      logic [3:0]  tx_cnt;    // Bits left to send
      ubm_pkg::ubm_fsm_e tx_st;
      logic        tx_line;   // Driven transmit level
      logic [7:0]  rx_sh;     // Receive shift
      logic [3:0]  rx_cnt;    // Bits received
      logic        rx_hold;   // Half-bit wait after start edge
      logic [4:0]  rx_half;   // Base ticks of that wait
      ubm_pkg::ubm_fsm_e rx_st;
      logic [7:0]  rx_buf;    // Receive buffer
      logic        rx_full;   // Buffer holds unread data
      logic [2:0]  err;       // Overrun and framing flags
      logic        rx_done;   // Reception complete pulse
      logic [7:0]  rdata;     // Read data
   } ubm_top_s;
   ubm_top_s st_reg;
   ubm_top_s st_next;

   logic       power;     // Internal clock enabled
   logic       tx_run;    // Transmitter out of reset
   logic       rx_run;    // Receiver out of reset
   logic       base_tick; // Selected base clock edge
   logic       rxd;       // Internal receive data
   logic       tx_tick;   // Transmit bit time
   logic       rx_tick;   // Receive bit time
   logic [4:0] k;         // Divisor value

   // Decode of a register address hit
   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction

   assign power  = st_reg.mode[`UBM_BIT_POWER];
   assign tx_run = power & st_reg.mode[`UBM_BIT_TXEN];
   assign rx_run = power & st_reg.mode[`UBM_BIT_RXEN];
   assign k      = st_reg.baud[4:0];
   // Base clock is held off without power
   always_comb begin
      unique case (ubm_pkg::ubm_clksel_e'(st_reg.baud[7:6]))
         ubm_pkg::UBM_CLK_TIMER: base_tick = st_reg.tmr_sync[1] &
                                             ~st_reg.tmr_sync[2];
         ubm_pkg::UBM_CLK_DIV2:  base_tick = st_reg.pre[0];
         ubm_pkg::UBM_CLK_DIV8:  base_tick = &st_reg.pre[2:0];
         ubm_pkg::UBM_CLK_DIV32: base_tick = &st_reg.pre;
      endcase
   end
   // Receive input reads high while unpowered
   assign rxd = power ? st_reg.rx_sync[1] : 1'b1;

   // ------------------------------------------------------------
   // Two independent dividers, one per direction
   // ------------------------------------------------------------
   ubm_divider u_tx_div (
      .clk_sys_in   (clk_sys_in),
      .srst_in      (srst_in),
      .run_in       (tx_run && st_reg.tx_st != ubm_pkg::UBM_IDLE),
      .base_tick_in (base_tick & power),
      .divisor_in   (k),
      .bit_tick_out (tx_tick)
   );
   ubm_divider u_rx_div (
      .clk_sys_in   (clk_sys_in),
      .srst_in      (srst_in),
      .run_in       (rx_run && st_reg.rx_st != ubm_pkg::UBM_IDLE &&
                     !st_reg.rx_hold),
      .base_tick_in (base_tick & power),
      .divisor_in   (k),
      .bit_tick_out (rx_tick)
   );

   // Next-state logic for registers, transmitter and receiver
   always_comb begin
      st_next = st_reg;
      st_next.rx_done = 1'b0;
      st_next.pre = st_reg.pre + 5'h01;
      // Timer input passes two flops before its edge is taken
      st_next.tmr_sync = {st_reg.tmr_sync[1:0], timer_output_clock_in};
      st_next.rx_sync  = {st_reg.rx_sync[0], serial_in_pin_in};
      // Register writes
      if (wr_in) begin
         if (hit(addr_in, `UBM_OFS_MODE)) begin
            st_next.mode = {wdata_in[7:1], 1'b1};
         end
         if (hit(addr_in, `UBM_OFS_BAUD)) begin
            // Divisor rewrite relies on enables being clear
            st_next.baud = wdata_in & `UBM_BAUD_WMASK;
         end
         if (hit(addr_in, `UBM_OFS_PORTDIR)) begin
            st_next.dir = wdata_in;
         end
         if (hit(addr_in, `UBM_OFS_PORTLATCH)) begin
            st_next.latch = wdata_in;
         end
      end
      // Transmitter: write starts a start bit plus eight data bits
      if (!tx_run) begin
         st_next.tx_st   = ubm_pkg::UBM_IDLE;
         st_next.tx_line = 1'b1;
      end else begin
         unique case (st_reg.tx_st)
            ubm_pkg::UBM_IDLE: begin
               if (wr_in && hit(addr_in, `UBM_OFS_TXSHIFT)) begin
                  st_next.tx_sh  = {wdata_in, 1'b0};
                  st_next.tx_cnt = `UBM_FRAME_BITS;
                  st_next.tx_st  = ubm_pkg::UBM_DATA;
                  st_next.tx_line = 1'b0;
               end
            end
            ubm_pkg::UBM_DATA: if (tx_tick) begin
               st_next.tx_sh  = {1'b1, st_reg.tx_sh[8:1]};
               st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
               st_next.tx_line = st_reg.tx_sh[1];
               if (st_reg.tx_cnt == 4'h1) begin
                  st_next.tx_line = 1'b1;
                  st_next.tx_cnt = {3'h0, st_reg.mode[`UBM_BIT_STOP2]};
                  st_next.tx_st  = ubm_pkg::UBM_STOP;
               end
            end
            ubm_pkg::UBM_STOP: if (tx_tick) begin
               st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
               if (st_reg.tx_cnt == 4'h0) begin
                  st_next.tx_st = ubm_pkg::UBM_IDLE;
               end
            end
            default: st_next.tx_st = ubm_pkg::UBM_IDLE;
         endcase
      end
      // Buffer and status read side effects
      if (rd_in && hit(addr_in, `UBM_OFS_RXBUF)) begin
         st_next.rx_full = 1'b0;
      end
      if (rd_in && hit(addr_in, `UBM_OFS_ERRSTAT)) begin
         st_next.err = '0;
      end
      // Receiver: falling edge, eight data bits, one stop bit
      if (!rx_run) begin
         st_next.rx_st = ubm_pkg::UBM_IDLE;
      end else begin
         unique case (st_reg.rx_st)
            ubm_pkg::UBM_IDLE: if (!rxd) begin
               st_next.rx_cnt  = '0;
               st_next.rx_hold = 1'b1;
               st_next.rx_half = '0;
               st_next.rx_st   = ubm_pkg::UBM_DATA;
            end
            ubm_pkg::UBM_DATA: if (st_reg.rx_hold) begin
               // Half a bit first, so samples land mid-bit, not on edges
               if (base_tick) begin
                  if (st_reg.rx_half == k - 5'h01) begin
                     st_next.rx_hold = 1'b0;
                  end else begin
                     st_next.rx_half = st_reg.rx_half + 5'h01;
                  end
               end
            end else if (rx_tick) begin
               st_next.rx_sh  = {rxd, st_reg.rx_sh[7:1]};
               st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
               if (st_reg.rx_cnt == 4'h8) begin
                  st_next.rx_sh = st_reg.rx_sh;
                  st_next.rx_st = ubm_pkg::UBM_STOP;
               end
            end
            ubm_pkg::UBM_STOP: begin
               // Stop bit was just sampled mid-bit; finish at once
               st_next.rx_st   = ubm_pkg::UBM_IDLE;
               st_next.rx_done = 1'b1;
               // Set wins over a read clearing the same cycle
               st_next.err[1]  = st_next.err[1] | ~rxd;
               if (st_reg.rx_full) begin
                  st_next.err[0] = 1'b1; // Overrun discards data
               end else begin
                  st_next.rx_buf  = st_reg.rx_sh;
                  st_next.rx_full = 1'b1;
               end
            end
            default: st_next.rx_st = ubm_pkg::UBM_IDLE;
         endcase
      end
      // Read data mux
      st_next.rdata = 8'h00;
      if (rd_in) begin
         if (hit(addr_in, `UBM_OFS_MODE))    st_next.rdata = st_reg.mode;
         if (hit(addr_in, `UBM_OFS_BAUD))    st_next.rdata = st_reg.baud;
         if (hit(addr_in, `UBM_OFS_PORTDIR)) st_next.rdata = st_reg.dir;
         if (hit(addr_in, `UBM_OFS_PORTLATCH)) st_next.rdata = st_reg.latch;
         if (hit(addr_in, `UBM_OFS_RXBUF))   st_next.rdata = st_reg.rx_buf;
         if (hit(addr_in, `UBM_OFS_ERRSTAT)) st_next.rdata = {5'h00, st_reg.err};
      end
      // Power off resets the internal circuit
      if (!power) begin
         st_next.tx_sh   = '0;
         st_next.rx_buf  = '0;
         st_next.rx_full = 1'b0;
         st_next.err     = '0;
         st_next.tx_line = 1'b1;
      end
   end

   // Register the state
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         st_reg       <= '0;
         st_reg.mode  <= `UBM_RST_MODE;
         st_reg.baud  <= `UBM_RST_BAUD;
         st_reg.dir   <= `UBM_RST_PORTDIR;
         st_reg.latch <= `UBM_RST_PORTLATCH;
         st_reg.tx_line <= 1'b1;
         st_reg.rx_sync <= 2'h3;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Pin routing
   // ------------------------------------------------------------
   // Serial drives the latch-gated line only while the transmitter is enabled
   always_comb begin
      if (tx_run) begin
         serial_out_pin_out = st_reg.tx_line & st_reg.latch[`UBM_BIT_TXPIN];
      end else begin
         serial_out_pin_out = st_reg.latch[`UBM_BIT_TXPIN];
      end
   end
   assign serial_out_pin_oe_out = ~st_reg.dir[`UBM_BIT_TXPIN];
   assign serial_in_pin_out     = st_reg.latch[`UBM_BIT_RXPIN];
   assign serial_in_pin_oe_out  = ~st_reg.dir[`UBM_BIT_RXPIN];
   assign rdata_out             = st_reg.rdata;
   assign rx_done_out           = st_reg.rx_done;
endmodule
`default_nettype wire

// ---- ubm_props.sv ----
// Checker for baud, mode and pin routing of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module ubm_props (
   input wire logic        clk_sys_in,
   input wire logic        srst_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        serial_out_pin_out,
   input wire logic        serial_out_pin_oe_out,
   input wire logic        serial_in_pin_out,
   input wire logic        serial_in_pin_oe_out,
   input wire logic        rx_done_out
);
   // Shadows of the writable registers, updated on the same edge
   logic [7:0] mode_reg, baud_reg, dir_reg, lat_reg;
   logic       fresh_reg; // Transmitter enabled, nothing written yet
   logic       tx_on, rx_on, wr_tx, rd_baud, rd_mode;
   assign tx_on = mode_reg[7] & mode_reg[6];
   assign rx_on = mode_reg[7] & mode_reg[5];
   assign wr_tx = wr_in && addr_in == `UBM_OFS_TXSHIFT;
   assign rd_baud = rd_in && addr_in == `UBM_OFS_BAUD;
   assign rd_mode = rd_in && addr_in == `UBM_OFS_MODE;
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         mode_reg <= `UBM_RST_MODE;
         baud_reg <= `UBM_RST_BAUD;
         dir_reg <= `UBM_RST_PORTDIR;
         lat_reg <= `UBM_RST_PORTLATCH;
         fresh_reg <= 1'b0;
      end else if (wr_in) begin
         case (addr_in)
            `UBM_OFS_MODE: mode_reg <= wdata_in | 8'h01;
            `UBM_OFS_BAUD: baud_reg <= wdata_in & `UBM_BAUD_WMASK;
            `UBM_OFS_PORTDIR: dir_reg <= wdata_in;
            `UBM_OFS_PORTLATCH: lat_reg <= wdata_in;
            default: ;
         endcase
         // Fresh only when the transmitter goes from off to on
         fresh_reg <= (addr_in == `UBM_OFS_MODE) ?
            (wdata_in[7] & wdata_in[6] & (fresh_reg | ~tx_on)) :
            (fresh_reg & ~wr_tx);
      end
   end
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);
   a_baud_rsvd_zero: assert property (rd_baud |=> !rdata_out[5])
      else $error("baud reserved bit read as one");
   a_baud_readback: assert property (rd_baud |=> rdata_out == $past(baud_reg))
      else $error("baud readback wrong");
   a_mode_readback: assert property (rd_mode |=> rdata_out == $past(mode_reg))
      else $error("mode readback wrong");
   a_tx_pin_oe: assert property (serial_out_pin_oe_out == !dir_reg[0])
      else $error("transmit pin enable wrong");
   a_rx_pin_route: assert property (serial_in_pin_oe_out == !dir_reg[1] && serial_in_pin_out == lat_reg[1])
      else $error("receive pin routing wrong");
   a_tx_pin_port: assert property ((!tx_on && !$past(tx_on) && $stable(lat_reg)) |-> serial_out_pin_out == lat_reg[0])
      else $error("transmit pin not port latch");
   a_start_bit: assert property ((wr_tx && tx_on && fresh_reg && lat_reg[0]) |-> ##[1:2] !serial_out_pin_out)
      else $error("no start bit after write");
   a_rx_off_quiet: assert property ((!rx_on && !$past(rx_on)) |-> !rx_done_out)
      else $error("receive done while disabled");
   a_done_pulse: assert property (rx_done_out |=> !rx_done_out)
      else $error("receive done longer than a cycle");
   c_rx_done: cover property (rx_done_out);
   c_tx_start: cover property (wr_tx && tx_on);
   c_baud_read: cover property (rd_baud);
endmodule
bind ubm_top ubm_props ubm_props_inst (.*);
`default_nettype wire

// ---- ubm_remote.sv ----
// Remote serial device facing the port, one frame at a time
`timescale 1ns/1ps
`default_nettype none
module ubm_remote (
   input  wire logic clk_sys_in,
   input  wire logic line_in,   // Port transmit pin
   output logic      line_out   // Port receive pin, idles high
);
   initial line_out = 1'b1;
   // Start bit, 8 data bits LSB first, one stop bit
   task automatic send(input logic [7:0] d, input int bt);
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_sys_in);
         line_out = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
         repeat (bt - 1) @(negedge clk_sys_in);
      end
   endtask
   // Mid-bit sampling; a wrong bit rate drifts off the data
   task automatic recv(input int bt, output logic [8:0] d, output bit ok);
      int n;
      n = 0;
      while (line_in !== 1'b0 && n < 30000) begin
         @(negedge clk_sys_in);
         n++;
      end
      ok = (n < 30000);
      repeat (bt / 2) @(negedge clk_sys_in);
      for (int i = 0; i < 9; i++) begin
         repeat (bt) @(negedge clk_sys_in);
         d[i] = line_in;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the serial baud and mode control block
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module tb_top;
   logic        clk_sys_in, srst_in, wr_in, rd_in, tmr, so, soe, si, sie;
   logic        done, rx_line;
   logic [15:0] addr_in;
   logic [7:0]  wdata_in, rdata_out, v, tx_b, rx_b;
   logic [8:0]  got;
   int          failures, num_checks, bt, k, n;
   bit          ok;
   ubm_top ubm_top_inst (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .timer_output_clock_in(tmr),
      .serial_in_pin_in(rx_line), .serial_out_pin_in(so),
      .serial_out_pin_out(so), .serial_out_pin_oe_out(soe),
      .serial_in_pin_out(si), .serial_in_pin_oe_out(sie),
      .rx_done_out(done));
   ubm_remote ubm_remote_inst (.clk_sys_in(clk_sys_in), .line_in(so),
      .line_out(rx_line));
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // Timer output runs before use, rising every 4 clocks
   initial begin
      tmr = 1'b0;
      forever begin
         repeat (2) @(negedge clk_sys_in);
         tmr = ~tmr;
      end
   end
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Bus tasks start and end at a falling edge
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      addr_in = a;
      wdata_in = d;
      wr_in = 1'b1;
      @(negedge clk_sys_in);
      wr_in = 1'b0;
      @(negedge clk_sys_in);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      addr_in = a;
      rd_in = 1'b1;
      @(negedge clk_sys_in);
      d = rdata_out;
      rd_in = 1'b0;
      @(negedge clk_sys_in);
   endtask
   task automatic wait_done(input int lim);
      n = 0;
      while (done !== 1'b1) begin
         if (n == lim) begin
            failures++;
            stop_test();
         end
         n++;
         @(negedge clk_sys_in);
      end
   endtask
   // Clocks per base tick for each select code, timer included
   function automatic int ticks(input int s);
      return (s == 0) ? 4 : (s == 1) ? 2 : (s == 2) ? 8 : 32;
   endfunction
   // Full duplex frame: remote sends rx_b while port sends tx_b
   task automatic duplex;
      tx_b = 8'($urandom);
      rx_b = 8'($urandom);
      fork
         ubm_remote_inst.recv(bt, got, ok);
         ubm_remote_inst.send(rx_b, bt);
         wr(`UBM_OFS_TXSHIFT, tx_b);
         wait_done(30 * bt);
      join
      check({8'h00, ok}, 9'h001);
      check(got, {1'b1, tx_b});
      rd(`UBM_OFS_RXBUF, v);
      check({1'b0, v}, {1'b0, rx_b});
   endtask
   initial begin
      srst_in = 1'b1;
      wr_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 16'h0000;
      wdata_in = 8'h00;
      void'($urandom(14));
      repeat (6) @(negedge clk_sys_in);
      srst_in = 1'b0;
      rd(`UBM_OFS_MODE, v);
      check({1'b0, v}, {1'b0, `UBM_RST_MODE});
      rd(`UBM_OFS_BAUD, v);
      check({1'b0, v}, 9'h01f);
      rd(`UBM_OFS_PORTDIR, v);
      check({1'b0, v}, 9'h0ff);
      rd(16'h0000, v);
      check({1'b0, v}, 9'h000);
      wr(`UBM_OFS_BAUD, 8'hff);
      rd(`UBM_OFS_BAUD, v);
      check({1'b0, v}, 9'h0df);
      wr(`UBM_OFS_PORTDIR, 8'hfe);
      wr(`UBM_OFS_PORTLATCH, 8'h01);
      check({6'h00, so, soe, sie}, 9'h006);
      // Every base clock source, boundary divisors at both ends
      for (int s = 0; s < 4; s++) begin
         k = (s == 3) ? 8 : (s == 0) ? 31 : 8 + ($urandom % 24);
         bt = 2 * k * ticks(s);
         wr(`UBM_OFS_MODE, 8'h01);
         wr(`UBM_OFS_BAUD, {s[1:0], 1'b0, k[4:0]});
         wr(`UBM_OFS_MODE, 8'h81);
         wr(`UBM_OFS_MODE, 8'he1);
         repeat (bt) @(negedge clk_sys_in);
         duplex();
      end
      // Power off clears buffer and status
      fork
         ubm_remote_inst.send(8'h5a, bt);
         wait_done(30 * bt);
      join
      wr(`UBM_OFS_MODE, 8'h81);
      wr(`UBM_OFS_MODE, 8'h01);
      rd(`UBM_OFS_RXBUF, v);
      check({1'b0, v}, 9'h000);
      rd(`UBM_OFS_ERRSTAT, v);
      check({1'b0, v}, 9'h000);
      // Transmit disable in mid-frame returns the pin to the latch
      wr(`UBM_OFS_MODE, 8'h81);
      wr(`UBM_OFS_MODE, 8'he1);
      repeat (bt) @(negedge clk_sys_in);
      wr(`UBM_OFS_TXSHIFT, 8'h00);
      repeat (bt) @(negedge clk_sys_in);
      wr(`UBM_OFS_MODE, 8'ha1);
      n = 0;
      repeat (2 * bt) begin
         @(negedge clk_sys_in);
         n += int'(!so);
      end
      check(9'(n), 9'h000);
      // Re-enabled transmitter starts idle, not in the cut frame
      wr(`UBM_OFS_MODE, 8'he1);
      n = 0;
      repeat (bt) begin
         @(negedge clk_sys_in);
         n += int'(!so);
      end
      check(9'(n), 9'h000);
      // Stop mode: both pins are plain port pins
      wr(`UBM_OFS_MODE, 8'h81);
      wr(`UBM_OFS_MODE, 8'h01);
      wr(`UBM_OFS_PORTLATCH, 8'h02);
      check({7'h00, so, si}, 9'h001);
      wr(`UBM_OFS_PORTDIR, 8'hff);
      check({7'h00, soe, sie}, 9'h000);
      stop_test();
   end
endmodule
`default_nettype wire
